// file: src/ckdp_cfg.svh
/*
  Constants for the sample clock divider, duty cycle stabilizer and power
  state control: register offsets, field positions, reset values, timing.
  Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef CKDP_CFG_SVH
`define CKDP_CFG_SVH

// ****************************************
// register offsets (13-bit serial port address space)
// ****************************************
`define CKDP_ADDR_DCS_CTRL   13'h009
`define CKDP_ADDR_DIV_RATIO  13'h00B
`define CKDP_ADDR_PWR_CTRL   13'h0F0
`define CKDP_ADDR_ALIGN_CTRL 13'h100
`define CKDP_ADDR_STATUS     13'h102

// ****************************************
// field positions
// ****************************************
`define CKDP_DCS_EN_BIT        0
`define CKDP_ALIGN_EN_BIT      1
`define CKDP_ALIGN_FIRST_BIT   2
`define CKDP_PWR_DOWN_BIT      0
`define CKDP_PWR_STBY_BIT      1
`define CKDP_PWR_PIN_STBY_BIT  5

// ****************************************
// reset values
// ****************************************
`define CKDP_RST_DCS_CTRL   8'h01
`define CKDP_RST_ALIGN_CTRL 8'h00
`define CKDP_RST_DIV_RATIO  4'h2
`define CKDP_RST_PWR_CTRL   8'h00

// ****************************************
// divider limits and rates
// ****************************************
`define CKDP_RATIO_MIN   4'h2
`define CKDP_RATIO_MAX   4'h8
`define CKDP_CLK_KHZ     200000
`define CKDP_DCS_MIN_KHZ 20000

// ****************************************
// timing
// ****************************************
`define CKDP_CLK_PERIOD_PS 5000
`define CKDP_DCS_LOCK_NS   1500
`define CKDP_RECHARGE_NS   2000
`define CKDP_STBY_WAKE_NS  200
`define CKDP_DCS_LOCK_CYC ((`CKDP_DCS_LOCK_NS*1000+`CKDP_CLK_PERIOD_PS-1)/`CKDP_CLK_PERIOD_PS)
`define CKDP_RECHARGE_CYC ((`CKDP_RECHARGE_NS*1000+`CKDP_CLK_PERIOD_PS-1)/`CKDP_CLK_PERIOD_PS)
`define CKDP_STBY_WAKE_CYC ((`CKDP_STBY_WAKE_NS*1000+`CKDP_CLK_PERIOD_PS-1)/`CKDP_CLK_PERIOD_PS)

`endif

// file: src/ckdp_pkg.sv
/*
  Types for the clock divider and power control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ckdp_pkg;

  // power state, one-hot
  typedef enum logic [3:0] {
    PWR_RUN  = 4'b0001,
    PWR_STBY = 4'b0010,
    PWR_DOWN = 4'b0100,
    PWR_WAKE = 4'b1000
  } ckdp_pwr_e;

  // stabilizer loop state, one-hot
  typedef enum logic [2:0] {
    DCS_OFF  = 3'b001,
    DCS_ACQ  = 3'b010,
    DCS_LOCK = 3'b100
  } ckdp_dcs_e;

endpackage

// file: src/ckdp_pin_sync.sv
/*
  Three-stage synchroniser for one pin with an agreement filter.
  Assumes the pin is asynchronous to core_clk_i.
*/
`timescale 1ns/1ps
module ckdp_pin_sync (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // pin and filtered level
  input wire logic pin_i,
  output logic level_o
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // s1 feeds only s2
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      level_o <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      level_o <= s3_reg;
    end
  end

endmodule

// file: src/ckdp_divider.sv
/*
  Integer divider of the sample clock producing the conversion clock.
  Assumes ratio_i already lies within 2..8 and align_i is a one-cycle pulse.
*/
`timescale 1ns/1ps
module ckdp_divider (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic run_i,
  input wire logic [3:0] ratio_i,
  input wire logic align_i,
  input wire logic dcs_active_i,
  // conversion clock
  output logic conv_clk_o,
  output logic fall_retime_o
);

  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [3:0] half;

  assign half = ratio_i >> 1;

  always_comb begin
    if (!run_i || align_i) begin
      cnt_next = 4'h0;
    end else if (cnt_reg >= ratio_i - 4'h1) begin
      cnt_next = 4'h0;
    end else begin
      cnt_next = cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= 4'h0;
      conv_clk_o <= 1'b0;
      fall_retime_o <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      // even ratios give equal high and low counts
      conv_clk_o <= run_i && (cnt_next < half);
      // odd ratio: falling edge moved half an input cycle later
      fall_retime_o <= run_i && dcs_active_i && ratio_i[0] && (cnt_next == half);
    end
  end

endmodule

// file: src/ckdp_top.sv
/*
  Clock path and power state control of the converter: sample clock
  divider with alignment, duty cycle stabilizer control and lock tracking,
  power-down and standby sequencing, and the serial port registers.
  Assumes core_clk_i is the undivided sample clock, the serial port engine
  outside hands in decoded byte accesses, and all pins are asynchronous.
*/
`timescale 1ns/1ps
`include "ckdp_cfg.svh"
module ckdp_top (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // decoded serial port access
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [12:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // configuration pins
  input wire logic serial_mode_pin_i,
  input wire logic stabilizer_select_pin_i,
  input wire logic power_down_pin_i,
  input wire logic align_pin_i,
  // conversion clock
  output logic conv_clk_o,
  output logic fall_retime_o,
  // stabilizer status
  output logic dcs_active_o,
  output logic dcs_locked_o,
  // power control
  output logic power_down_o,
  output logic standby_o,
  output logic ref_pwr_o,
  output logic bias_pwr_o,
  output logic clk_pwr_o,
  output logic data_drv_en_o,
  output logic ready_o
);

  // ****************************************
  // constants
  // ****************************************
  localparam logic [8:0] LOCK_CYC = 9'(`CKDP_DCS_LOCK_CYC);
  localparam logic [9:0] RECHARGE_CYC = 10'(`CKDP_RECHARGE_CYC);
  localparam logic [9:0] STBY_WAKE_CYC = 10'(`CKDP_STBY_WAKE_CYC);
  localparam int PIN_CNT = 4;

  // ****************************************
  // declarations
  // ****************************************
  logic [PIN_CNT-1:0] pin_raw;
  logic [PIN_CNT-1:0] pin_lvl;
  logic serial_mode;
  logic stab_sel;
  logic pd_pin;
  logic align_lvl;
  logic align_lvl_d_reg;
  logic align_edge;
  logic realign;

  logic [7:0] dcs_ctrl_reg;
  logic [7:0] align_ctrl_reg;
  logic [7:0] pwr_ctrl_reg;
  logic [3:0] div_ratio_reg;
  logic [3:0] ratio_wr;
  logic align_armed_reg;

  logic wr_dcs;
  logic wr_align;
  logic wr_pwr;
  logic wr_div;

  logic dcs_en;
  logic rate_ok;
  logic clk_running;
  logic dcs_want;
  logic [3:0] ratio_seen_reg;
  logic ratio_changed;
  ckdp_pkg::ckdp_dcs_e dcs_state_reg;
  ckdp_pkg::ckdp_dcs_e dcs_state_next;
  logic [8:0] lock_cnt_reg;

  logic pd_req;
  logic sb_req;
  ckdp_pkg::ckdp_pwr_e pwr_state_reg;
  ckdp_pkg::ckdp_pwr_e pwr_state_next;
  logic [9:0] wake_cnt_reg;

  logic [7:0] status;
  logic [7:0] rdata_next;

  // ****************************************
  // pin synchronisers
  // ****************************************
  assign pin_raw = {align_pin_i, power_down_pin_i, stabilizer_select_pin_i, serial_mode_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_CNT; gi = gi + 1) begin : g_pin
      ckdp_pin_sync u_sync (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(pin_raw[gi]),
        .level_o(pin_lvl[gi])
      );
    end
  endgenerate

  assign serial_mode = pin_lvl[0];
  assign stab_sel = pin_lvl[1];
  assign pd_pin = pin_lvl[2];
  assign align_lvl = pin_lvl[3];

  // ****************************************
  // register write decode
  // ****************************************
  assign wr_dcs = reg_wr_i && (reg_addr_i == `CKDP_ADDR_DCS_CTRL);
  assign wr_align = reg_wr_i && (reg_addr_i == `CKDP_ADDR_ALIGN_CTRL);
  assign wr_pwr = reg_wr_i && (reg_addr_i == `CKDP_ADDR_PWR_CTRL);
  assign wr_div = reg_wr_i && (reg_addr_i == `CKDP_ADDR_DIV_RATIO);

  // out-of-range ratios are clamped, so the divider never sees 0, 1 or >8
  always_comb begin
    if (reg_wdata_i[3:0] < `CKDP_RATIO_MIN) begin
      ratio_wr = `CKDP_RATIO_MIN;
    end else if (reg_wdata_i[3:0] > `CKDP_RATIO_MAX || reg_wdata_i[7:4] != 4'h0) begin
      ratio_wr = `CKDP_RATIO_MAX;
    end else begin
      ratio_wr = reg_wdata_i[3:0];
    end
  end

  // stabilizer control, enabled out of reset
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      dcs_ctrl_reg <= `CKDP_RST_DCS_CTRL;
    end else if (wr_dcs) begin
      dcs_ctrl_reg <= reg_wdata_i;
    end
  end

  // divide ratio
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      div_ratio_reg <= `CKDP_RST_DIV_RATIO;
    end else if (wr_div) begin
      div_ratio_reg <= ratio_wr;
    end
  end

  // power mode and pin function
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pwr_ctrl_reg <= `CKDP_RST_PWR_CTRL;
    end else if (wr_pwr) begin
      pwr_ctrl_reg <= reg_wdata_i;
    end
  end

  // alignment control
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      align_ctrl_reg <= `CKDP_RST_ALIGN_CTRL;
    end else if (wr_align) begin
      align_ctrl_reg <= reg_wdata_i;
    end
  end

  // ****************************************
  // alignment
  // ****************************************
  // edge found on the undivided clock, divider restarts next edge
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      align_lvl_d_reg <= 1'b0;
    end else begin
      align_lvl_d_reg <= align_lvl;
    end
  end

  assign align_edge = align_lvl && !align_lvl_d_reg;

  // every pulse, or only the first after the write
  assign realign = align_edge && clk_running &&
                   align_ctrl_reg[`CKDP_ALIGN_EN_BIT] &&
                   (!align_ctrl_reg[`CKDP_ALIGN_FIRST_BIT] || align_armed_reg);

  // a write in the same cycle as a consumed pulse re-arms: the write wins
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      align_armed_reg <= 1'b0;
    end else if (wr_align) begin
      align_armed_reg <= 1'b1;
    end else if (realign && align_ctrl_reg[`CKDP_ALIGN_FIRST_BIT]) begin
      align_armed_reg <= 1'b0;
    end
  end

  // ****************************************
  // divider
  // ****************************************
  ckdp_divider u_div (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(clk_running),
    .ratio_i(div_ratio_reg),
    .align_i(realign),
    .dcs_active_i(dcs_state_next == ckdp_pkg::DCS_LOCK),
    .conv_clk_o(conv_clk_o),
    .fall_retime_o(fall_retime_o)
  );

  // ****************************************
  // duty cycle stabilizer
  // ****************************************
  // pin mode follows the select pin, serial mode the register
  assign dcs_en = serial_mode ? dcs_ctrl_reg[`CKDP_DCS_EN_BIT] : stab_sel;

  // conversion rate must reach the loop's lower limit
  assign rate_ok = (`CKDP_CLK_KHZ >= `CKDP_DCS_MIN_KHZ * int'(div_ratio_reg));
  assign clk_running = (pwr_state_reg == ckdp_pkg::PWR_RUN) ||
                       (pwr_state_reg == ckdp_pkg::PWR_WAKE);
  assign dcs_want = dcs_en && rate_ok && clk_running;

  // a ratio change is a frequency change seen by the loop
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ratio_seen_reg <= `CKDP_RST_DIV_RATIO;
    end else begin
      ratio_seen_reg <= div_ratio_reg;
    end
  end

  assign ratio_changed = ratio_seen_reg != div_ratio_reg;

  always_comb begin
    dcs_state_next = dcs_state_reg;
    case (dcs_state_reg)
      ckdp_pkg::DCS_OFF: begin
        if (dcs_want) begin
          dcs_state_next = ckdp_pkg::DCS_ACQ;
        end
      end
      ckdp_pkg::DCS_ACQ: begin
        if (!dcs_want) begin
          dcs_state_next = ckdp_pkg::DCS_OFF;
        end else if (!ratio_changed && lock_cnt_reg >= LOCK_CYC - 9'h001) begin
          dcs_state_next = ckdp_pkg::DCS_LOCK;
        end
      end
      ckdp_pkg::DCS_LOCK: begin
        if (!dcs_want) begin
          dcs_state_next = ckdp_pkg::DCS_OFF;
        end else if (ratio_changed) begin
          dcs_state_next = ckdp_pkg::DCS_ACQ; // relock after rate change
        end
      end
      default: begin
        dcs_state_next = ckdp_pkg::DCS_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      dcs_state_reg <= ckdp_pkg::DCS_OFF;
    end else begin
      dcs_state_reg <= dcs_state_next;
    end
  end

  // lock wait counter; restarts on any rate change
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      lock_cnt_reg <= 9'h000;
    end else if (dcs_state_reg != ckdp_pkg::DCS_ACQ || ratio_changed) begin
      lock_cnt_reg <= 9'h000;
    end else if (lock_cnt_reg != LOCK_CYC) begin
      lock_cnt_reg <= lock_cnt_reg + 9'h001;
    end
  end

  // retiming only while locked, otherwise bypassed
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      dcs_active_o <= 1'b0;
      dcs_locked_o <= 1'b0;
    end else begin
      dcs_active_o <= dcs_state_next == ckdp_pkg::DCS_LOCK;
      dcs_locked_o <= dcs_state_next == ckdp_pkg::DCS_LOCK;
    end
  end

  // ****************************************
  // power state
  // ****************************************
  // pin mode: pin alone; serial mode: register or pin per its function
  always_comb begin
    if (!serial_mode) begin
      pd_req = pd_pin;
      sb_req = 1'b0;
    end else begin
      pd_req = pwr_ctrl_reg[`CKDP_PWR_DOWN_BIT] ||
               (pd_pin && !pwr_ctrl_reg[`CKDP_PWR_PIN_STBY_BIT]);
      sb_req = pwr_ctrl_reg[`CKDP_PWR_STBY_BIT] ||
               (pd_pin && pwr_ctrl_reg[`CKDP_PWR_PIN_STBY_BIT]);
    end
  end

  always_comb begin
    pwr_state_next = pwr_state_reg;
    case (pwr_state_reg)
      ckdp_pkg::PWR_RUN: begin
        if (pd_req) begin
          pwr_state_next = ckdp_pkg::PWR_DOWN;
        end else if (sb_req) begin
          pwr_state_next = ckdp_pkg::PWR_STBY;
        end
      end
      ckdp_pkg::PWR_STBY: begin
        if (pd_req) begin
          pwr_state_next = ckdp_pkg::PWR_DOWN;
        end else if (!sb_req) begin
          pwr_state_next = ckdp_pkg::PWR_WAKE;
        end
      end
      ckdp_pkg::PWR_DOWN: begin
        if (!pd_req && sb_req) begin
          pwr_state_next = ckdp_pkg::PWR_STBY;
        end else if (!pd_req) begin
          pwr_state_next = ckdp_pkg::PWR_WAKE; // pin low returns
        end
      end
      ckdp_pkg::PWR_WAKE: begin
        if (pd_req) begin
          pwr_state_next = ckdp_pkg::PWR_DOWN;
        end else if (sb_req) begin
          pwr_state_next = ckdp_pkg::PWR_STBY;
        end else if (wake_cnt_reg == 10'h000) begin
          pwr_state_next = ckdp_pkg::PWR_RUN;
        end
      end
      default: begin
        pwr_state_next = ckdp_pkg::PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pwr_state_reg <= ckdp_pkg::PWR_RUN;
    end else begin
      pwr_state_reg <= pwr_state_next;
    end
  end

  // recharge wait; standby keeps the reference up so its wait is shorter
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wake_cnt_reg <= 10'h000;
    end else if (pwr_state_reg == ckdp_pkg::PWR_DOWN) begin
      wake_cnt_reg <= RECHARGE_CYC - 10'h001;
    end else if (pwr_state_reg == ckdp_pkg::PWR_STBY) begin
      wake_cnt_reg <= STBY_WAKE_CYC - 10'h001;
    end else if (wake_cnt_reg != 10'h000) begin
      wake_cnt_reg <= wake_cnt_reg - 10'h001;
    end
  end

  // supplies and drivers follow the next state
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      power_down_o <= 1'b0;
      standby_o <= 1'b0;
      ref_pwr_o <= 1'b1;
      bias_pwr_o <= 1'b1;
      clk_pwr_o <= 1'b1;
      data_drv_en_o <= 1'b1;
      ready_o <= 1'b1;
    end else begin
      power_down_o <= pwr_state_next == ckdp_pkg::PWR_DOWN;
      standby_o <= pwr_state_next == ckdp_pkg::PWR_STBY;
      ref_pwr_o <= pwr_state_next != ckdp_pkg::PWR_DOWN;
      bias_pwr_o <= pwr_state_next == ckdp_pkg::PWR_RUN ||
                    pwr_state_next == ckdp_pkg::PWR_WAKE;
      clk_pwr_o <= pwr_state_next == ckdp_pkg::PWR_RUN ||
                   pwr_state_next == ckdp_pkg::PWR_WAKE;
      // drivers stay high-Z until the capacitors have recharged
      data_drv_en_o <= pwr_state_next == ckdp_pkg::PWR_RUN;
      ready_o <= pwr_state_next == ckdp_pkg::PWR_RUN;
    end
  end

  // ****************************************
  // register read
  // ****************************************
  assign status = {1'b0,
                   !rate_ok,
                   pwr_state_reg == ckdp_pkg::PWR_WAKE,
                   align_armed_reg,
                   pwr_state_reg == ckdp_pkg::PWR_STBY,
                   pwr_state_reg == ckdp_pkg::PWR_DOWN,
                   dcs_en,
                   dcs_state_reg == ckdp_pkg::DCS_LOCK};

  // unmapped addresses read as zero
  always_comb begin
    if (reg_addr_i == `CKDP_ADDR_DCS_CTRL) begin
      rdata_next = dcs_ctrl_reg;
    end else if (reg_addr_i == `CKDP_ADDR_DIV_RATIO) begin
      rdata_next = {4'h0, div_ratio_reg};
    end else if (reg_addr_i == `CKDP_ADDR_PWR_CTRL) begin
      rdata_next = pwr_ctrl_reg;
    end else if (reg_addr_i == `CKDP_ADDR_ALIGN_CTRL) begin
      rdata_next = align_ctrl_reg;
    end else if (reg_addr_i == `CKDP_ADDR_STATUS) begin
      rdata_next = status;
    end else begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_next;
      end
    end
  end

endmodule

// file: tb/ckdp_top_props.sv
/*
  Port checker for ckdp_top, attached to every instance by bind.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module ckdp_top_props (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // watched ports
  input wire logic reg_rd_i,
  input wire logic reg_rvalid_o,
  input wire logic serial_mode_pin_i,
  input wire logic power_down_pin_i,
  input wire logic fall_retime_o,
  input wire logic dcs_locked_o,
  input wire logic power_down_o,
  input wire logic standby_o,
  input wire logic ref_pwr_o,
  input wire logic bias_pwr_o,
  input wire logic clk_pwr_o,
  input wire logic data_drv_en_o,
  input wire logic ready_o
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_rd_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read without answer");
  a_rvalid_cause: assert property ($rose(reg_rvalid_o) |-> $past(reg_rd_i))
    else $error("answer without read");
  a_down_all_off: assert property (power_down_o |->
    !data_drv_en_o && !ref_pwr_o && !bias_pwr_o && !clk_pwr_o)
    else $error("power-down leaves a supply on");
  a_stby_ref_kept: assert property (standby_o |-> ref_pwr_o && !data_drv_en_o)
    else $error("standby state wrong");
  a_bypass_unlocked: assert property (!dcs_locked_o |-> !fall_retime_o)
    else $error("retime while unlocked");
  a_pin_enters_down: assert property (
    (!serial_mode_pin_i && power_down_pin_i) [*8] |-> power_down_o)
    else $error("pin did not power down");
  a_pin_leaves_down: assert property (
    (!serial_mode_pin_i && !power_down_pin_i) [*8] |-> !power_down_o)
    else $error("pin did not release power-down");
  a_ready_powered: assert property (ready_o |->
    data_drv_en_o && ref_pwr_o && bias_pwr_o && clk_pwr_o)
    else $error("ready without power");
  a_wake_recharge: assert property ($fell(power_down_o) |-> !ready_o [*8])
    else $error("no recharge time");
  a_one_state: assert property (!(standby_o && power_down_o) && !(ready_o && standby_o))
    else $error("two power states at once");
  c_down: cover property (power_down_o);
  c_stby: cover property (standby_o);
  c_retime: cover property ($rose(fall_retime_o));
endmodule

bind ckdp_top ckdp_top_props i_props (.core_clk_i, .sys_rst_i, .reg_rd_i, .reg_rvalid_o,
  .serial_mode_pin_i, .power_down_pin_i, .fall_retime_o, .dcs_locked_o, .power_down_o,
  .standby_o, .ref_pwr_o, .bias_pwr_o, .clk_pwr_o, .data_drv_en_o, .ready_o);

// file: tb/ckdp_host_model.sv
/*
  Host side model: drives the configuration, power and alignment pins.
  Assumes the bench calls its tasks at a falling clock edge.
*/
`timescale 1ns/1ps
module ckdp_host_model (
  // clock
  input wire logic core_clk_i,
  // pins
  output logic serial_mode_pin_o,
  output logic stabilizer_select_pin_o,
  output logic power_down_pin_o,
  output logic align_pin_o
);
  // ****************
  // pin drivers
  // ****************
  initial begin
    serial_mode_pin_o = 1'b1;
    stabilizer_select_pin_o = 1'b0;
    power_down_pin_o = 1'b0;
    align_pin_o = 1'b0;
  end
  task automatic set_pins(logic s, logic d, logic p);
    serial_mode_pin_o = s;
    stabilizer_select_pin_o = d;
    power_down_pin_o = p;
  endtask
  // held 4 cycles: a pulse under 2 cycles could slip past the pin filter
  task automatic pulse_align();
    align_pin_o = 1'b1;
    repeat (4) @(negedge core_clk_i);
    align_pin_o = 1'b0;
  endtask
  // lock is not trusted until 1.5 us after a rate change
  task automatic wait_relock();
    repeat (300) @(negedge core_clk_i);
  endtask
endmodule

// file: tb/ckdp_top_bench.sv
/*
  Self-checking bench for ckdp_top with the host pin model.
  Assumes a 50% duty sample clock, so even ratios need no stabilizer.
*/
`timescale 1ns/1ps
module ckdp_top_bench;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [12:0] reg_addr_i = 13'h000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic reg_rvalid_o, serial_mode_pin_i, stabilizer_select_pin_i, power_down_pin_i;
  logic align_pin_i, conv_clk_o, fall_retime_o, dcs_active_o, dcs_locked_o, power_down_o;
  logic standby_o, ref_pwr_o, bias_pwr_o, clk_pwr_o, data_drv_en_o, ready_o;
  int error_cnt = 0;
  int num_checks = 0;
  ckdp_top i_dut (.core_clk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .serial_mode_pin_i, .stabilizer_select_pin_i,
    .power_down_pin_i, .align_pin_i, .conv_clk_o, .fall_retime_o, .dcs_active_o,
    .dcs_locked_o, .power_down_o, .standby_o, .ref_pwr_o, .bias_pwr_o, .clk_pwr_o,
    .data_drv_en_o, .ready_o);
  ckdp_host_model i_host (.core_clk_i, .serial_mode_pin_o(serial_mode_pin_i),
    .stabilizer_select_pin_o(stabilizer_select_pin_i),
    .power_down_pin_o(power_down_pin_i), .align_pin_o(align_pin_i));
  // ****************
  // helpers
  // ****************
  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic logic sel(int k);
    case (k)
      0: return power_down_o;
      1: return standby_o;
      2: return ready_o;
      3: return dcs_locked_o;
      default: return conv_clk_o;
    endcase
  endfunction
  // k: 0 down, 1 standby, 2 ready, 3 locked, 4 conversion clock
  task automatic wait_for(int k, logic v, int lim, output int n);
    n = 0;
    while (sel(k) !== v && n < lim) begin
      @(negedge core_clk_i);
      n++;
    end
    if (n >= lim) begin
      chk("wait bound", 16'h0001, 16'h0000);
      close_out();
    end
  endtask
  task automatic wr(logic [12:0] a, logic [7:0] d);
    @(negedge core_clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd_chk(logic [12:0] a, logic [7:0] exp);
    @(negedge core_clk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    chk("rvalid", {15'h0000, reg_rvalid_o}, 16'h0001);
    chk("rdata", {8'h00, reg_rdata_o}, {8'h00, exp});
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_regs();
    rd_chk(13'h009, 8'h01);
    rd_chk(13'h100, 8'h00);
    rd_chk(13'h055, 8'h00);
    wr(13'h100, 8'h06);
    rd_chk(13'h100, 8'h06);
  endtask
  task automatic t_div();
    int n, h, p, e;
    for (int r = 1; r <= 9; r++) begin
      e = r < 2 ? 2 : (r > 8 ? 8 : r);
      wr(13'h00B, 8'(r));
      repeat (20) @(negedge core_clk_i);
      wait_for(4, 1'b0, 20, n);
      wait_for(4, 1'b1, 20, n);
      wait_for(4, 1'b0, 20, h);
      wait_for(4, 1'b1, 20, p);
      chk("high run", 16'(h), 16'(e / 2));
      chk("period", 16'(h + p), 16'(e));
    end
    rd_chk(13'h00B, 8'h08);
  endtask
  task automatic t_dcs();
    int n;
    wr(13'h00B, 8'h03);
    i_host.wait_relock();
    wait_for(3, 1'b1, 60, n);
    // retime pulse stands one input cycle per period
    for (int i = 0; i < 3 && !fall_retime_o; i++) begin
      @(negedge core_clk_i);
    end
    chk("retime", {dcs_active_o, fall_retime_o, conv_clk_o}, 16'h0006);
    wr(13'h00B, 8'h04);
    wait_for(3, 1'b0, 8, n);
    wr(13'h009, 8'h00);
    repeat (400) @(negedge core_clk_i);
    chk("dcs off", {dcs_locked_o, fall_retime_o}, 16'h0000);
    i_host.set_pins(1'b0, 1'b1, 1'b0);
    i_host.wait_relock();
    wait_for(3, 1'b1, 60, n);
    i_host.set_pins(1'b0, 1'b0, 1'b0);
    wait_for(3, 1'b0, 10, n);
    i_host.set_pins(1'b1, 1'b0, 1'b0);
    wr(13'h009, 8'h01);
  endtask
  // realigned unless the next rise comes a full ratio-8 period later
  task automatic try_align(logic exp);
    int n1, n2;
    repeat (8) @(negedge core_clk_i);
    wait_for(4, 1'b0, 20, n1);
    wait_for(4, 1'b1, 20, n1);
    fork
      i_host.pulse_align();
      begin
        wait_for(4, 1'b0, 20, n1);
        wait_for(4, 1'b1, 20, n2);
      end
    join
    chk("realign", {15'h0000, n1 + n2 != 8}, {15'h0000, exp});
  endtask
  task automatic t_align();
    wr(13'h00B, 8'h08);
    wr(13'h100, 8'h06);
    try_align(1'b1);
    try_align(1'b0);
    wr(13'h100, 8'h06);
    try_align(1'b1);
    wr(13'h100, 8'h02);
    try_align(1'b1);
    try_align(1'b1);
    wr(13'h100, 8'h00);
    try_align(1'b0);
  endtask
  task automatic t_power();
    int n;
    i_host.set_pins(1'b0, 1'b0, 1'b1);
    wait_for(0, 1'b1, 10, n);
    chk("down outs", {ref_pwr_o, bias_pwr_o, clk_pwr_o, data_drv_en_o}, 16'h0);
    i_host.set_pins(1'b0, 1'b0, 1'b0);
    wait_for(0, 1'b0, 10, n);
    wait_for(2, 1'b1, 420, n);
    chk("recharge", {15'h0000, n > 390}, 16'h0001);
    i_host.set_pins(1'b1, 1'b0, 1'b0);
    wr(13'h0F0, 8'h01);
    wait_for(0, 1'b1, 5, n);
    wr(13'h0F0, 8'h00);
    wait_for(2, 1'b1, 420, n);
    wr(13'h0F0, 8'h02);
    wait_for(1, 1'b1, 5, n);
    chk("standby", {ref_pwr_o, data_drv_en_o, power_down_o}, 16'h0004);
    rd_chk(13'h102, 8'h1A);
    wr(13'h0F0, 8'h00);
    wait_for(2, 1'b1, 100, n);
    chk("fast wake", {15'h0000, n < 60}, 16'h0001);
    wr(13'h0F0, 8'h20);
    i_host.set_pins(1'b1, 1'b0, 1'b1);
    wait_for(1, 1'b1, 10, n);
    chk("pin standby", {15'h0000, power_down_o}, 16'h0000);
    wr(13'h0F0, 8'h00);
    wait_for(0, 1'b1, 10, n);
    i_host.set_pins(1'b1, 1'b0, 1'b0);
    wait_for(2, 1'b1, 420, n);
  endtask
  initial begin
    repeat (12) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    t_regs();
    t_div();
    t_dcs();
    t_align();
    t_power();
    close_out();
  end
endmodule
